// ---- pkg/pd_irq_map.svh ----
// Contract
// - After reset each combined pin is a power-down input; interrupt output is off.
// - Output-select bit 0 of irq_control (11h) makes the pin an active-low interrupt.
// - Each port has its own pin; one port's power-down never touches the other.
// - Low pin while an input powers the port down, same as bit 11 of 00h.
// - A pin held low from reset brings the port up already powered down.
// - Management register accesses keep working while the port is powered down.
// - Setting output-select stops the pin input, so a pin-held port wakes.
// - After reset every interrupt source is disabled.
// - Pin carries interrupts only with global enable bit 1; each source masked in 12h low byte.
// - An enabled interrupt condition drives the pin low at once, without a clock edge.
// - Upper byte of 12h shows one flag per pending source, all visible together.
// - Reading 12h clears together the flags it returns; a flag set during the read stays and keeps the pin low, else the pin returns high.
// - 0003h to 11h sets enable and output-select; 0060h to 12h unmasks ED and link.
// - Energy detect on with no cable activity keeps the port low-power, still watching.
// - Line activity during energy-detect low power runs the normal power-up sequence.
// - In energy-detect mode the transmitter wakes periodically to send energy pulses.
// - Energy detect is enabled and configured through its own register at 1Dh.
`ifndef PD_IRQ_MAP_SVH
`define PD_IRQ_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index, plus 80h for port b)
// ----------------------------------------------------------------------
`define BASIC_MODE_CONTROL_IDX    5'h00
`define IRQ_CONTROL_IDX           5'h11
`define IRQ_STATUS_MASK_IDX       5'h12
`define ENERGY_DETECT_CONTROL_IDX 5'h1d
`define PORT_SEL_ADDR_HI          11
`define PORT_SEL_ADDR_LO          7
`define PORT_A_SEL                5'h00
`define PORT_B_SEL                5'h01
`define SYS_IRQ_STATUS_ADDR       12'h100
`define SYS_IRQ_MASK_ADDR         12'h104

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define BMC_POWER_DOWN_BIT        11
`define IRQC_OUTPUT_SEL_BIT       0
`define IRQC_GLOBAL_EN_BIT        1
`define SRC_LINK_CHANGE_BIT       5
`define SRC_ENERGY_CHANGE_BIT     6
`define EDC_ENABLE_BIT            15

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BASIC_MODE_CONTROL_RST    16'h0000
`define IRQ_CONTROL_RST           2'h0
`define IRQ_MASK_RST              8'h00
`define ENERGY_DETECT_CONTROL_RST 16'h0000
`define SYS_IRQ_MASK_RST          4'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_MHZ                   40
`define ED_QUIET_US               1000
`define ED_PULSE_PERIOD_US        256
`define ED_POWERUP_US             20

`endif

// ---- pkg/pd_irq_pkg.sv ----
package pd_irq_pkg;

  typedef enum logic [1:0] {
    ED_AWAKE  = 2'b00,
    ED_SLEEP  = 2'b01,
    ED_WAKING = 2'b10
  } ed_state_t;

  typedef logic [15:0] reg16_t;

endpackage

// ---- rtl/phy_powerdown_irq_energy_detect.sv ----
`timescale 1ns/100ps
`include "pd_irq_map.svh"

module phy_powerdown_irq_energy_detect #(
  parameter int unsigned ED_QUIET_CYC  = `ED_QUIET_US * `CLK_MHZ,
  parameter int unsigned ED_PULSE_CYC  = `ED_PULSE_PERIOD_US * `CLK_MHZ,
  parameter int unsigned ED_POWERUP_CYC = `ED_POWERUP_US * `CLK_MHZ
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  // port a combined pin and line side
  input  wire logic        pd_irq_pin_port_a_in_i,
  output logic             pd_irq_pin_port_a_out_o,
  output logic             pd_irq_pin_port_a_oe_n_o,
  input  wire logic        link_up_a_i,
  input  wire logic        line_energy_a_i,
  input  wire logic [7:0]  src_event_a_i,
  output logic             power_down_a_o,
  output logic             low_power_a_o,
  output logic             ed_tx_pulse_a_o,
  // port b combined pin and line side
  input  wire logic        pd_irq_pin_port_b_in_i,
  output logic             pd_irq_pin_port_b_out_o,
  output logic             pd_irq_pin_port_b_oe_n_o,
  input  wire logic        link_up_b_i,
  input  wire logic        line_energy_b_i,
  input  wire logic [7:0]  src_event_b_i,
  output logic             power_down_b_o,
  output logic             low_power_b_o,
  output logic             ed_tx_pulse_b_o
);
  import pd_irq_pkg::*;

  // ----------------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------------
  logic        setup_ph;
  logic        access_ph;
  logic        wr_acc;
  logic        rd_acc;
  logic [4:0]  reg_idx;
  logic [4:0]  port_sel;
  logic [1:0]  pin_in;
  logic [1:0]  link_in;
  logic [1:0]  energy_in;
  logic [7:0]  ext_evt   [2];
  wire  [15:0] port_rdata [2];
  wire  [1:0]  port_hit;
  wire  [1:0]  port_mapped;
  wire  [1:0]  pin_oe_n;
  wire  [1:0]  pd_state;
  wire  [1:0]  lp_state;
  wire  [1:0]  tx_pulse;
  wire  [3:0]  sys_ev;
  logic [3:0]  sys_status;
  logic [3:0]  sys_mask;
  logic        sys_st_hit;
  logic        sys_mk_hit;

  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign wr_acc    = access_ph & pwrite_i;
  assign rd_acc    = access_ph & ~pwrite_i;
  assign reg_idx   = paddr_i[6:2];
  assign port_sel  = paddr_i[`PORT_SEL_ADDR_HI:`PORT_SEL_ADDR_LO];
  assign pready_o  = access_ph;
  assign sys_st_hit = (paddr_i == `SYS_IRQ_STATUS_ADDR);
  assign sys_mk_hit = (paddr_i == `SYS_IRQ_MASK_ADDR);

  assign pin_in    = {pd_irq_pin_port_b_in_i, pd_irq_pin_port_a_in_i};
  assign link_in   = {link_up_b_i, link_up_a_i};
  assign energy_in = {line_energy_b_i, line_energy_a_i};
  assign ext_evt[0] = src_event_a_i;
  assign ext_evt[1] = src_event_b_i;

  assign port_hit[0] = (port_sel == `PORT_A_SEL);
  assign port_hit[1] = (port_sel == `PORT_B_SEL);

  // ----------------------------------------------------------------------
  // per-port power-down, interrupt and energy-detect logic
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : port_g
    logic        pin_meta;
    logic        pin_sync;
    logic [15:0] basic_mode_control;
    logic        irq_output_sel;
    logic        irq_global_enable;
    logic [7:0]  irq_mask;
    logic [7:0]  irq_pending;
    logic [7:0]  rd_snap;
    logic [15:0] energy_detect_control;
    logic        link_q;
    logic        link_evt;
    logic        energy_change_pending_evt;
    logic [7:0]  src_now;
    logic [7:0]  src_masked;
    logic        irq_active;
    logic        pd_now;
    logic        power_down;
    ed_state_t   ed_state;
    ed_state_t   next_ed_state;
    logic [19:0] ed_cnt;
    logic [19:0] next_ed_cnt;
    logic        ed_pulse;
    logic        next_ed_pulse;
    logic        ed_en;
    logic        wr_here;
    logic        rd_status_here;

    assign wr_here        = wr_acc & port_hit[g];
    assign rd_status_here = rd_acc & port_hit[g] & (reg_idx == `IRQ_STATUS_MASK_IDX);
    assign ed_en          = energy_detect_control[`EDC_ENABLE_BIT];

    // reset value 0 means powered down until the pin is seen high
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        pin_meta <= 1'b0;
        pin_sync <= 1'b0;
      end else begin
        pin_meta <= pin_in[g];
        pin_sync <= pin_meta;
      end
    end

    // management registers, reachable in any power state
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        basic_mode_control    <= `BASIC_MODE_CONTROL_RST;
        irq_output_sel        <= 1'b0;
        irq_global_enable     <= 1'b0;
        irq_mask              <= `IRQ_MASK_RST;
        energy_detect_control <= `ENERGY_DETECT_CONTROL_RST;
      end else if (wr_here) begin
        case (reg_idx)
          `BASIC_MODE_CONTROL_IDX: basic_mode_control <= pwdata_i[15:0];
          `IRQ_CONTROL_IDX: begin
            irq_output_sel    <= pwdata_i[`IRQC_OUTPUT_SEL_BIT];
            irq_global_enable <= pwdata_i[`IRQC_GLOBAL_EN_BIT];
          end
          `IRQ_STATUS_MASK_IDX: irq_mask <= pwdata_i[7:0];
          `ENERGY_DETECT_CONTROL_IDX: energy_detect_control <= pwdata_i[15:0];
          default: ;
        endcase
      end
    end

    // interrupt sources
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        link_q <= 1'b0;
      end else begin
        link_q <= link_in[g];
      end
    end

    assign link_evt = link_in[g] ^ link_q;

    always_comb begin
      src_now = ext_evt[g];
      src_now[`SRC_LINK_CHANGE_BIT]   = src_now[`SRC_LINK_CHANGE_BIT] | link_evt;
      src_now[`SRC_ENERGY_CHANGE_BIT] = src_now[`SRC_ENERGY_CHANGE_BIT]
                                        | energy_change_pending_evt;
    end

    assign src_masked = src_now & irq_mask;

    // flags captured in setup are the ones cleared at the access edge
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        rd_snap <= 8'h00;
      end else if (setup_ph) begin
        rd_snap <= irq_pending;
      end
    end

    // new events win over the read clear
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        irq_pending <= 8'h00;
      end else if (rd_status_here) begin
        irq_pending <= (irq_pending & ~rd_snap) | src_masked;
      end else begin
        irq_pending <= irq_pending | src_masked;
      end
    end

    // pin drive is combinational so an event pulls it low at once
    assign irq_active = irq_global_enable & (|irq_pending | |src_masked);
    assign pin_oe_n[g] = ~(irq_output_sel & irq_active);

    // power state
    assign pd_now = basic_mode_control[`BMC_POWER_DOWN_BIT]
                    | (~irq_output_sel & ~pin_sync);

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        power_down <= 1'b1;
      end else begin
        power_down <= pd_now;
      end
    end

    // energy detect sequencer
    always_comb begin
      next_ed_state = ed_state;
      next_ed_cnt   = ed_cnt + 20'h00001;
      next_ed_pulse = 1'b0;
      case (ed_state)
        ED_AWAKE: begin
          if (!ed_en || energy_in[g] || power_down) begin
            next_ed_cnt = 20'h00000;
          end else if (ed_cnt == 20'(ED_QUIET_CYC - 1)) begin
            next_ed_state = ED_SLEEP;
            next_ed_cnt   = 20'h00000;
          end
        end
        ED_SLEEP: begin
          if (!ed_en || energy_in[g]) begin
            next_ed_state = ED_WAKING;
            next_ed_cnt   = 20'h00000;
          end else if (ed_cnt == 20'(ED_PULSE_CYC - 1)) begin
            next_ed_pulse = 1'b1;
            next_ed_cnt   = 20'h00000;
          end
        end
        ED_WAKING: begin
          if (ed_cnt == 20'(ED_POWERUP_CYC - 1)) begin
            next_ed_state = ED_AWAKE;
            next_ed_cnt   = 20'h00000;
          end
        end
        default: begin
          next_ed_state = ED_AWAKE;
          next_ed_cnt   = 20'h00000;
        end
      endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        ed_state <= ED_AWAKE;
        ed_cnt   <= 20'h00000;
        ed_pulse <= 1'b0;
        energy_change_pending_evt <= 1'b0;
      end else begin
        ed_state <= next_ed_state;
        ed_cnt   <= next_ed_cnt;
        ed_pulse <= next_ed_pulse;
        energy_change_pending_evt <= (next_ed_state == ED_SLEEP) != (ed_state == ED_SLEEP);
      end
    end

    // read data and event hand-off to the shared part
    assign port_mapped[g] = (reg_idx == `BASIC_MODE_CONTROL_IDX)
                          | (reg_idx == `IRQ_CONTROL_IDX)
                          | (reg_idx == `IRQ_STATUS_MASK_IDX)
                          | (reg_idx == `ENERGY_DETECT_CONTROL_IDX);
    assign port_rdata[g] =
      (reg_idx == `BASIC_MODE_CONTROL_IDX)    ? basic_mode_control :
      (reg_idx == `IRQ_CONTROL_IDX)           ? {14'h0000, irq_global_enable, irq_output_sel} :
      (reg_idx == `IRQ_STATUS_MASK_IDX)       ? {irq_pending, irq_mask} :
      (reg_idx == `ENERGY_DETECT_CONTROL_IDX) ? energy_detect_control : 16'h0000;
    assign pd_state[g] = power_down;
    assign lp_state[g] = (ed_state == ED_SLEEP);
    assign tx_pulse[g] = ed_pulse;
    assign sys_ev[2*g]   = |src_masked;
    assign sys_ev[2*g+1] = pd_now & ~power_down;
  end

  // ----------------------------------------------------------------------
  // pins and line-side outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd_irq_pin_port_a_out_o <= 1'b0;
      pd_irq_pin_port_b_out_o <= 1'b0;
    end else begin
      pd_irq_pin_port_a_out_o <= 1'b0;
      pd_irq_pin_port_b_out_o <= 1'b0;
    end
  end

  assign pd_irq_pin_port_a_oe_n_o = pin_oe_n[0];
  assign pd_irq_pin_port_b_oe_n_o = pin_oe_n[1];
  assign power_down_a_o  = pd_state[0];
  assign power_down_b_o  = pd_state[1];
  assign low_power_a_o   = lp_state[0];
  assign low_power_b_o   = lp_state[1];
  assign ed_tx_pulse_a_o = tx_pulse[0];
  assign ed_tx_pulse_b_o = tx_pulse[1];

  // ----------------------------------------------------------------------
  // system interrupt status and mask
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_mask <= `SYS_IRQ_MASK_RST;
    end else if (wr_acc && sys_mk_hit) begin
      sys_mask <= pwdata_i[3:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_status <= 4'h0;
    end else if (wr_acc && sys_st_hit) begin
      sys_status <= (sys_status & ~pwdata_i[3:0]) | sys_ev;
    end else begin
      sys_status <= sys_status | sys_ev;
    end
  end

  assign irq_o = |(sys_status & sys_mask);

  // ----------------------------------------------------------------------
  // read data and error, registered in the setup cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup_ph) begin
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (sys_st_hit) begin
        prdata_o <= {28'h0000000, sys_status};
      end else if (sys_mk_hit) begin
        prdata_o <= {28'h0000000, sys_mask};
      end else if (port_hit[0] && port_mapped[0] && paddr_i[1:0] == 2'b00) begin
        prdata_o <= {16'h0000, port_rdata[0]};
      end else if (port_hit[1] && port_mapped[1] && paddr_i[1:0] == 2'b00) begin
        prdata_o <= {16'h0000, port_rdata[1]};
      end else begin
        pslverr_o <= 1'b1;
      end
    end
  end

endmodule // phy_powerdown_irq_energy_detect

// ---- verification/pd_irq_asserts.sv ----
`timescale 1ns/100ps
`include "pd_irq_map.svh"

module pd_irq_asserts #(
  parameter int unsigned ED_PULSE_CYC = 8
) (
  // clock and apb
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  // port pins and line side
  input wire logic        pd_irq_pin_port_a_in_i,
  input wire logic        pd_irq_pin_port_a_oe_n_o,
  input wire logic        link_up_a_i,
  input wire logic        line_energy_a_i,
  input wire logic [7:0]  src_event_a_i,
  input wire logic        power_down_a_o,
  input wire logic        low_power_a_o,
  input wire logic        ed_tx_pulse_a_o,
  input wire logic        pd_irq_pin_port_b_in_i,
  input wire logic        power_down_b_o
);
  // ----------------------------------------------------------------
  // shadow of the written control bits
  // ----------------------------------------------------------------
  localparam logic [11:0] CTL_A = {`PORT_A_SEL, `IRQ_CONTROL_IDX, 2'b00};
  localparam logic [11:0] ST_A  = {`PORT_A_SEL, `IRQ_STATUS_MASK_IDX, 2'b00};
  localparam logic [11:0] BMC_A = {`PORT_A_SEL, `BASIC_MODE_CONTROL_IDX, 2'b00};
  localparam logic [11:0] BMC_B = {`PORT_B_SEL, `BASIC_MODE_CONTROL_IDX, 2'b00};
  logic        wr;
  logic        rd_st;
  logic [1:0]  ctl;
  logic [7:0]  msk;
  logic        bmc_a;
  logic        bmc_b;
  int unsigned gap;

  assign wr    = psel_i && penable_i && pwrite_i;
  assign rd_st = psel_i && penable_i && !pwrite_i && paddr_i == ST_A;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl   <= 2'h0;
      msk   <= 8'h00;
      bmc_a <= 1'b0;
      bmc_b <= 1'b0;
    end else if (wr) begin
      if (paddr_i == CTL_A) ctl <= pwdata_i[1:0];
      if (paddr_i == ST_A) msk <= pwdata_i[7:0];
      if (paddr_i == BMC_A) bmc_a <= pwdata_i[`BMC_POWER_DOWN_BIT];
      if (paddr_i == BMC_B) bmc_b <= pwdata_i[`BMC_POWER_DOWN_BIT];
    end
  end

  // sleep cycles since the last energy pulse
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) gap <= 0;
    else if (low_power_a_o && !ed_tx_pulse_a_o) gap <= gap + 1;
    else gap <= 0;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_quiet;
    !(|(src_event_a_i & msk)) && $stable(link_up_a_i) && $stable(low_power_a_o);
  endsequence
  sequence s_held;
    !pd_irq_pin_port_a_oe_n_o && !rd_st ##1 ctl == 2'h3;
  endsequence

  a_pin_released_off: assert property (ctl != 2'h3 |-> pd_irq_pin_port_a_oe_n_o)
    else $error("pin driven while interrupt output is off");
  a_event_pulls_pin: assert property (ctl == 2'h3 && |(src_event_a_i & msk)
    |-> !pd_irq_pin_port_a_oe_n_o) else $error("masked event did not pull the pin");
  a_pending_holds_pin: assert property (s_held |-> !pd_irq_pin_port_a_oe_n_o)
    else $error("pin released without a status read");
  a_read_releases_pin: assert property (s_quiet [*3] ##0 rd_st ##1 s_quiet
    |-> pd_irq_pin_port_a_oe_n_o) else $error("pin still low after status read");
  a_pin_powers_down: assert property ((!pd_irq_pin_port_a_in_i && !ctl[0]) [*3]
    |=> power_down_a_o) else $error("low pin did not power the port down");
  a_outsel_wakes: assert property (ctl[0] && !bmc_a |=> !power_down_a_o)
    else $error("output select did not release power down");
  a_bmc_powers_down: assert property (bmc_a |=> power_down_a_o)
    else $error("control bit did not power the port down");
  a_portb_own_pin: assert property ((nrst_i && pd_irq_pin_port_b_in_i && !bmc_b) [*3]
    |=> !power_down_b_o) else $error("port b down with its pin high");
  a_ed_pulse_gap: assert property (gap <= ED_PULSE_CYC + 1)
    else $error("no energy pulse within the pulse period");
  a_energy_wakes: assert property (low_power_a_o && line_energy_a_i
    |-> ##[1:3] !low_power_a_o) else $error("line activity did not wake the port");
endmodule // pd_irq_asserts

bind phy_powerdown_irq_energy_detect pd_irq_asserts #(
  .ED_PULSE_CYC(ED_PULSE_CYC)
) pd_irq_asserts_inst (.*);

// ---- verification/host_pin_model.sv ----
`timescale 1ns/100ps

module host_pin_model (
  // clock
  input  wire logic       core_clk_i,
  // device drive of the combined pin
  input  wire logic       out_i,
  input  wire logic       oe_n_i,
  input  wire logic       peer_out_i,
  input  wire logic       peer_oe_n_i,
  // host side
  input  wire logic       wired_i,
  input  wire logic       strap_low_i,
  input  wire logic       pd_req_i,
  input  wire logic [3:0] lag_i,
  output logic            pin_o
);
  logic       pd_drv = 1'b0;
  logic [3:0] cnt = 4'h0;

  // host follows its power-down request lag_i + 1 cycles after it changes
  always_ff @(posedge core_clk_i) begin
    if (pd_req_i == pd_drv) begin
      cnt <= 4'h0;
    end else if (cnt >= lag_i) begin
      pd_drv <= pd_req_i;
      cnt    <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  // open-drain line with pull-up: any low driver wins
  assign pin_o = (oe_n_i | out_i) & (!wired_i | peer_oe_n_i | peer_out_i)
               & !pd_drv & !strap_low_i;
endmodule // host_pin_model

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
`include "pd_irq_map.svh"

module tb_top;
  logic        core_clk_i = 1'b0, nrst_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        pready_o, pslverr_o, irq_o, err;
  logic        in_a, out_a, oe_n_a, pd_a, lp_a, tx_a, in_b, out_b, oe_n_b, pd_b, lp_b, tx_b;
  logic        link_a = 1'b0, nrg_a = 1'b1, link_b = 1'b0, nrg_b = 1'b1;
  logic [7:0]  ev_a = 8'h00, ev_b = 8'h00, m_msk [2] = '{8'h00, 8'h00};
  logic        wired = 1'b0, strap_a = 1'b1, req_b = 1'b0, m_on [2] = '{1'b0, 1'b0};
  logic [3:0]  lag = 4'h5;
  logic [4:0]  idx_list [4] = '{5'h00, 5'h11, 5'h12, 5'h1d};
  int          error_cnt = 0, num_checks = 0, n, m_pend [2] = '{0, 0};

  always #12.5 core_clk_i = ~core_clk_i;

  phy_powerdown_irq_energy_detect #(
    .ED_QUIET_CYC(20), .ED_PULSE_CYC(8), .ED_POWERUP_CYC(4)
  ) phy_powerdown_irq_energy_detect_inst (
    .core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .irq_o, .pd_irq_pin_port_a_in_i(in_a),
    .pd_irq_pin_port_a_out_o(out_a), .pd_irq_pin_port_a_oe_n_o(oe_n_a), .link_up_a_i(link_a),
    .line_energy_a_i(nrg_a), .src_event_a_i(ev_a), .power_down_a_o(pd_a),
    .low_power_a_o(lp_a), .ed_tx_pulse_a_o(tx_a), .pd_irq_pin_port_b_in_i(in_b),
    .pd_irq_pin_port_b_out_o(out_b), .pd_irq_pin_port_b_oe_n_o(oe_n_b), .link_up_b_i(link_b),
    .line_energy_b_i(nrg_b), .src_event_b_i(ev_b), .power_down_b_o(pd_b),
    .low_power_b_o(lp_b), .ed_tx_pulse_b_o(tx_b));
  host_pin_model host_pin_model_inst (.core_clk_i, .out_i(out_a), .oe_n_i(oe_n_a),
    .peer_out_i(out_b), .peer_oe_n_i(oe_n_b), .wired_i(wired), .strap_low_i(strap_a),
    .pd_req_i(1'b0), .lag_i(lag), .pin_o(in_a));
  host_pin_model host_pin_b_inst (.core_clk_i, .out_i(out_b), .oe_n_i(oe_n_b),
    .peer_out_i(out_a), .peer_oe_n_i(oe_n_a), .wired_i(wired), .strap_low_i(1'b0),
    .pd_req_i(req_b), .lag_i(lag), .pin_o(in_b));

  // ----------------------------------------------------------------
  // bus tasks and model
  // ----------------------------------------------------------------
  function automatic logic [11:0] ra(input logic p, input logic [4:0] idx);
    return {4'h0, p, idx, 2'b00};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic p, input logic [4:0] idx, input logic [15:0] d);
    apb(1'b1, ra(p, idx), {16'h0, d});
    if (idx == `IRQ_STATUS_MASK_IDX) m_msk[p] = d[7:0];
    if (idx == `IRQ_CONTROL_IDX) m_on[p] = d[1:0] == 2'h3;
  endtask

  task automatic fire(input logic p, input logic [7:0] ev);
    @(posedge core_clk_i);
    if (p) ev_b <= ev;
    else ev_a <= ev;
    m_pend[p] = m_pend[p] | 32'(ev & m_msk[p]);
    @(negedge core_clk_i);
    check("pin on event", !(m_on[p] && m_pend[p] != 0), p ? oe_n_b : oe_n_a);
    @(posedge core_clk_i);
    if (p) ev_b <= 8'h00;
    else ev_a <= 8'h00;
  endtask

  task automatic read_status(input logic p);
    apb(1'b0, ra(p, `IRQ_STATUS_MASK_IDX), 32'h0);
    check("status", {16'h0, m_pend[p][7:0], m_msk[p]}, rd);
    m_pend[p] = 0;
    @(negedge core_clk_i);
    check("pin after read", 1, p ? oe_n_b : oe_n_a);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge core_clk_i);
    error_cnt++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h032a));
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    check("pd_a strapped", 1, pd_a);
    check("pd_b", 0, pd_b);
    foreach (idx_list[i]) begin
      apb(1'b0, ra(1'b0, idx_list[i]), 32'h0);
      check("reset value", 0, rd);
    end
    n = $urandom & 32'hf7ff;
    wr(0, `BASIC_MODE_CONTROL_IDX, n[15:0]);
    apb(1'b0, ra(1'b0, `BASIC_MODE_CONTROL_IDX), 32'h0);
    check("access while down", n, rd);
    wr(0, `IRQ_CONTROL_IDX, 16'h0003);
    repeat (3) @(posedge core_clk_i);
    check("pd_a after output select", 0, pd_a);
    strap_a <= 1'b0;
    wr(0, `IRQ_STATUS_MASK_IDX, 16'h0060);
    link_a <= 1'b1;
    m_pend[0] = 32'h20;
    repeat (3) @(posedge core_clk_i);
    check("pin on link change", 0, oe_n_a);
    check("pin drive value", 0, {out_a, out_b});
    read_status(0);
    for (int i = 0; i < 8; i++) begin
      wr(0, `IRQ_STATUS_MASK_IDX, 16'($urandom) & 16'h00ff);
      fire(0, 8'($urandom));
      fire(0, 8'($urandom));
      read_status(0);
    end
    wr(0, `IRQ_STATUS_MASK_IDX, 16'h00ff);
    wr(0, `IRQ_CONTROL_IDX, 16'h0001);
    fire(0, 8'h81);
    read_status(0);
    wr(0, `IRQ_CONTROL_IDX, 16'h0003);
    req_b <= 1'b1;
    repeat (12) @(posedge core_clk_i);
    check("pd_b by pin", 1, pd_b);
    check("pd_a untouched", 0, pd_a);
    req_b <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    check("pd_b released", 0, pd_b);
    wr(0, `BASIC_MODE_CONTROL_IDX, 16'h0800);
    repeat (2) @(posedge core_clk_i);
    check("pd_a by control bit", 1, pd_a);
    wr(0, `BASIC_MODE_CONTROL_IDX, 16'h0000);
    apb(1'b0, `SYS_IRQ_STATUS_ADDR, 32'h0);
    check("b entered power down", 32'h8, rd & 32'h8);
    apb(1'b1, `SYS_IRQ_MASK_ADDR, 32'h8);
    @(negedge core_clk_i);
    check("irq unmasked", 1, irq_o);
    apb(1'b1, `SYS_IRQ_MASK_ADDR, 32'h0);
    @(negedge core_clk_i);
    check("irq masked", 0, irq_o);
    apb(1'b1, `SYS_IRQ_STATUS_ADDR, 32'hf);
    apb(1'b0, `SYS_IRQ_STATUS_ADDR, 32'h0);
    check("status cleared", 0, rd);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped error", 1, err);
    check("unmapped data", 0, rd);
    wr(1, `IRQ_CONTROL_IDX, 16'h0003);
    wr(1, `IRQ_STATUS_MASK_IDX, 16'h00ff);
    wired <= 1'b1;
    fire(1, 8'h01);
    read_status(0);
    check("shared line low", 0, in_a);
    read_status(1);
    check("shared line high", 1, in_a);
    wr(0, `IRQ_STATUS_MASK_IDX, 16'h0040);
    wired <= 1'b0;
    nrg_a <= 1'b0;
    wr(0, `ENERGY_DETECT_CONTROL_IDX, 16'h8000);
    m_pend[0] = 32'h40;
    for (int i = 0; i < 60 && lp_a !== 1'b1; i++) @(posedge core_clk_i);
    check("low power", 1, lp_a);
    n = 0;
    repeat (20) @(posedge core_clk_i) n += int'(tx_a);
    check("energy pulses", 1, n >= 2);
    check("port b stays awake", 0, {lp_b, tx_b});
    nrg_a <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    check("woken", 0, lp_a);
    repeat (8) @(posedge core_clk_i);
    read_status(0);
    give_verdict();
  end
endmodule // tb_top
